// [core/xbc_defs.svh]
/*
 external bus control constants: register byte offsets, field positions, reset values, clocks per cycle.
 assumes inclusion by bare name from core design files.
*/
`ifndef XBC_DEFS_SVH
`define XBC_DEFS_SVH

`define XBC_OFF_BUS_CONTROL   12'h000
`define XBC_OFF_PIN_LEVELS    12'h004
`define XBC_OFF_DIRECTION     12'h008
`define XBC_OFF_OUTPUT_LATCH  12'h00c
`define XBC_OFF_MODE_CONTROL  12'h010
`define XBC_OFF_TABLE_LATCH   12'h014
`define XBC_OFF_STATUS        12'h018

`define XBC_BIT_RELEASE       7
`define XBC_BIT_WAIT_HI       5
`define XBC_BIT_WAIT_LO       4
`define XBC_BIT_WM_HI         1
`define XBC_BIT_WM_LO         0
`define XBC_CTRL_WMASK        8'hb3

`define XBC_BIT_MC_INTERNAL   0
`define XBC_BIT_MC_WIDE       1
`define XBC_BIT_MC_PSP        2
`define XBC_BIT_MC_LOWPOWER   3

`define XBC_RST_CTRL          8'h00
`define XBC_RST_DIR           8'hff
`define XBC_RST_LATCH         8'h00

`define XBC_CYCLE_CLKS        3'd4

`endif

// [core/xbc_pkg.sv]
/*
 external bus control types.
 assumes nothing beyond the defs header.
*/
package xbc_pkg;
    typedef enum logic [2:0] {XBC_IDLE, XBC_ADDR, XBC_WAIT, XBC_DATA, XBC_DONE} xbc_state_t;
endpackage

// [core/xbc_bus_ctrl.sv]
/*
 external memory bus control with port d pin mux, axi4-lite register slave.
 assumes one 25 mhz clock, synchronous active-high reset, inputs synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "xbc_defs.svh"

// How it works
// - internal-only mode blocks control register writes
// - release bit zero keeps bus owning pins
// - release bit one frees pins except accesses
// - release bit resets to zero
// - wait field adds three minus code cycles
// - write mode matters only at 16-bit width
// - word mode drives both latches, high strobe on upper access
// - byte select copies byte, strobe plus enable
// - bits 6,3,2 read zero
// - slow run clock just slows bus cycles
// - sleep/idle freezes bus pins
// - sleep/idle force enables high
// - direction one input, zero drives latch
// - latch reads return latch not pins
// - reset makes port pins inputs
// - enabled bus owns port, overrides direction
// - parallel port beats io, yields bus
// - address/data drive beats all, ignores direction
module xbc_bus_ctrl
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cycle_enable,
    input  wire logic        sleep_idle,
    input  wire logic        mem_req,
    input  wire logic        mem_write,
    input  wire logic        mem_upper,
    input  wire logic [7:0]  mem_addr,
    output logic             mem_done,
    output logic [7:0]       mem_rdata,
    input  wire logic [7:0]  psp_rd_data,
    input  wire logic        psp_drive,
    input  wire logic [7:0]  port_d_in,
    output logic [7:0]       port_d_out,
    output logic [7:0]       port_d_oe,
    output logic [7:0]       ad_high_out,
    output logic             ttl_buffers,
    output logic             ale,
    output logic             write_high_strobe,
    output logic             chip_enable_n,
    output logic             upper_byte_enable_n,
    output logic             lower_byte_enable_n
);
    logic [7:0]  external_bus_control;
    logic [7:0]  port_d_direction_bits;
    logic [7:0]  port_d_output_latch;
    logic [3:0]  mode_control;
    logic [7:0]  table_latch_low;
    logic [7:0]  table_latch_high;
    logic [7:0]  port_d_pin_levels;
    xbc_pkg::xbc_state_t state;
    logic [1:0]  wait_left;
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic        wr_ok;
    logic        bus_on;
    logic        wide;
    logic        internal_only;
    logic        psp_on;
    logic        upper_sel;
    logic        is_write;
    logic [7:0]  addr_hold;
    logic [7:0]  next_port_out;
    logic [7:0]  next_port_oe;
    logic [31:0] next_rdata;

    assign internal_only = mode_control[`XBC_BIT_MC_INTERNAL];
    assign wide = mode_control[`XBC_BIT_MC_WIDE];
    assign psp_on = mode_control[`XBC_BIT_MC_PSP];
    assign bus_on = !internal_only
        && (!external_bus_control[`XBC_BIT_RELEASE] || state != xbc_pkg::XBC_IDLE);

    // axi write side: address and data taken in either order
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_ok = wr_fire && (aw_addr == `XBC_OFF_BUS_CONTROL || aw_addr == `XBC_OFF_PIN_LEVELS
        || aw_addr == `XBC_OFF_DIRECTION || aw_addr == `XBC_OFF_OUTPUT_LATCH
        || aw_addr == `XBC_OFF_MODE_CONTROL || aw_addr == `XBC_OFF_TABLE_LATCH
        || aw_addr == `XBC_OFF_STATUS);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // register writes; byte lane 0 carries data, lane 1 only for the table latch high byte
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            external_bus_control <= `XBC_RST_CTRL;
            port_d_direction_bits <= `XBC_RST_DIR;
            port_d_output_latch <= `XBC_RST_LATCH;
            mode_control <= 4'h0;
            table_latch_low <= 8'h00;
            table_latch_high <= 8'h00;
        end
        else if (wr_fire && w_strb[0])
        begin
            unique case (aw_addr)
                `XBC_OFF_BUS_CONTROL:
                    if (!internal_only)
                        external_bus_control <= w_data[7:0] & `XBC_CTRL_WMASK;
                `XBC_OFF_PIN_LEVELS,
                `XBC_OFF_OUTPUT_LATCH:
                    port_d_output_latch <= w_data[7:0];
                `XBC_OFF_DIRECTION:
                    port_d_direction_bits <= w_data[7:0];
                `XBC_OFF_MODE_CONTROL:
                    mode_control <= w_data[3:0];
                `XBC_OFF_TABLE_LATCH:
                begin
                    table_latch_low <= w_data[7:0];
                    if (w_strb[1])
                        table_latch_high <= w_data[15:8];
                end
                default:
                    ;
            endcase
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case ({s_axi_araddr[11:2], 2'b00})
            `XBC_OFF_BUS_CONTROL:  next_rdata[7:0] = external_bus_control & `XBC_CTRL_WMASK;
            `XBC_OFF_PIN_LEVELS:   next_rdata[7:0] = port_d_pin_levels;
            `XBC_OFF_DIRECTION:    next_rdata[7:0] = port_d_direction_bits;
            `XBC_OFF_OUTPUT_LATCH: next_rdata[7:0] = port_d_output_latch;
            `XBC_OFF_MODE_CONTROL: next_rdata[3:0] = mode_control;
            `XBC_OFF_TABLE_LATCH:  next_rdata[15:0] = {table_latch_high, table_latch_low};
            `XBC_OFF_STATUS:       next_rdata[3:0] = {bus_on, (state == xbc_pkg::XBC_IDLE) ? 3'd0 : 3'd1};
            default:               next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= (s_axi_araddr[11:2] > 10'd6) ? 2'b10 : 2'b00;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            port_d_pin_levels <= 8'h00;
        else
            port_d_pin_levels <= port_d_in;
    end

    // bus cycle engine; cycle_enable marks each instruction cycle, so a slower
    // run clock just stretches the access and wait states grow in real time
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= xbc_pkg::XBC_IDLE;
            wait_left <= 2'd0;
            is_write <= 1'b0;
            upper_sel <= 1'b0;
            addr_hold <= 8'h00;
            mem_done <= 1'b0;
            mem_rdata <= 8'h00;
        end
        else
        begin
            mem_done <= 1'b0;
            if (cycle_enable && !sleep_idle)
            begin
                unique case (state)
                    xbc_pkg::XBC_IDLE:
                        if (mem_req && !internal_only)
                        begin
                            state <= xbc_pkg::XBC_ADDR;
                            is_write <= mem_write;
                            upper_sel <= mem_upper;
                            addr_hold <= mem_addr;
                        end
                    xbc_pkg::XBC_ADDR:
                    begin
                        wait_left <= 2'd3 - external_bus_control[`XBC_BIT_WAIT_HI:`XBC_BIT_WAIT_LO];
                        state <= xbc_pkg::XBC_WAIT;
                    end
                    xbc_pkg::XBC_WAIT:
                        if (wait_left == 2'd0)
                            state <= xbc_pkg::XBC_DATA;
                        else
                            wait_left <= wait_left - 2'd1;
                    xbc_pkg::XBC_DATA:
                    begin
                        mem_rdata <= port_d_in;
                        state <= xbc_pkg::XBC_DONE;
                    end
                    xbc_pkg::XBC_DONE:
                    begin
                        mem_done <= 1'b1;
                        state <= xbc_pkg::XBC_IDLE;
                    end
                    default:
                        state <= xbc_pkg::XBC_IDLE;
                endcase
            end
        end
    end

    // pin drive; in sleep/idle the enables are forced high and the other registers hold, freezing their pins
    always_comb
    begin
        next_port_out = port_d_output_latch;
        next_port_oe = ~port_d_direction_bits;
        if (psp_on && psp_drive)
        begin
            next_port_out = psp_rd_data;
            next_port_oe = 8'hff;
        end
        if (bus_on)
        begin
            next_port_oe = 8'h00;
            if (state == xbc_pkg::XBC_ADDR || state == xbc_pkg::XBC_WAIT)
            begin
                next_port_out = addr_hold;
                next_port_oe = 8'hff;
            end
            else if (state == xbc_pkg::XBC_DATA && is_write)
            begin
                // word and byte-select modes keep the low latch on the low byte lane
                next_port_out = table_latch_low;
                if (wide && upper_sel && external_bus_control[`XBC_BIT_WM_HI:`XBC_BIT_WM_LO] == 2'b00)
                    next_port_out = table_latch_high;
                next_port_oe = 8'hff;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            port_d_out <= 8'h00;
            port_d_oe <= 8'h00;
            ad_high_out <= 8'h00;
            ttl_buffers <= 1'b0;
            ale <= 1'b0;
            write_high_strobe <= 1'b0;
            chip_enable_n <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
        end
        else if (sleep_idle)
        begin
            chip_enable_n <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
        end
        else
        begin
            port_d_out <= next_port_out;
            port_d_oe <= next_port_oe;
            ttl_buffers <= psp_on || bus_on;
            ale <= bus_on && state == xbc_pkg::XBC_ADDR;
            chip_enable_n <= !(bus_on && state != xbc_pkg::XBC_IDLE);
            write_high_strobe <= 1'b0;
            upper_byte_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
            ad_high_out <= 8'h00;
            if (state == xbc_pkg::XBC_DATA && is_write && bus_on)
            begin
                if (!wide)
                    lower_byte_enable_n <= 1'b0;
                else if (external_bus_control[`XBC_BIT_WM_HI])
                begin
                    ad_high_out <= table_latch_high;
                    write_high_strobe <= upper_sel;
                    upper_byte_enable_n <= 1'b0;
                    lower_byte_enable_n <= 1'b0;
                end
                else if (external_bus_control[`XBC_BIT_WM_LO])
                begin
                    ad_high_out <= table_latch_low;
                    write_high_strobe <= 1'b1;
                    upper_byte_enable_n <= !upper_sel;
                    lower_byte_enable_n <= upper_sel;
                end
                else
                    lower_byte_enable_n <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/xbc_mem_model.sv]
/*
 external memory partner: answers reads on port d.
 assumes the address byte sits on port d while ale is high.
*/
`timescale 1ns/10ps
`default_nettype none
module xbc_mem_model
(
    input  wire logic       sys_clk,
    input  wire logic       ale,
    input  wire logic       chip_enable_n,
    input  wire logic [7:0] port_d_out,
    input  wire logic [7:0] port_d_oe,
    output logic [7:0]      port_d_in
);
    logic [7:0] addr_q = 8'h00;
    logic [7:0] idle_q = 8'h55;
    // unselected wire flips every cycle so a stale byte never passes
    always_ff @(posedge sys_clk)
    begin
        idle_q <= ~idle_q;
        if (ale)
            addr_q <= port_d_out;
    end
    // content is address xor 5a, cheap to predict
    assign port_d_in = (port_d_oe & port_d_out)
                     | (~port_d_oe & ((chip_enable_n || ale) ? idle_q : (addr_q ^ 8'h5a)));
endmodule
`default_nettype wire

// [sim/xbc_bus_ctrl_asserts.sv]
/*
 port checks for the bus control block.
 assumes a bind onto xbc_bus_ctrl.
*/
`timescale 1ns/10ps
`default_nettype none
module xbc_bus_ctrl_asserts
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       sleep_idle,
    input wire logic [7:0] mem_addr,
    input wire logic       mem_done,
    input wire logic [7:0] port_d_out,
    input wire logic [7:0] port_d_oe,
    input wire logic       ttl_buffers,
    input wire logic       ale,
    input wire logic       chip_enable_n,
    input wire logic       upper_byte_enable_n,
    input wire logic       lower_byte_enable_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // first sleep edge may still finish its update
    sequence s_asleep;
        sleep_idle ##1 sleep_idle;
    endsequence
    a_reset_port_off: assert property (disable iff (1'b0) rst |=> port_d_oe == 8'h00 && chip_enable_n)
        else $error("port driven out of reset");
    a_sleep_enables_high: assert property (s_asleep |-> chip_enable_n && upper_byte_enable_n && lower_byte_enable_n)
        else $error("enable low in sleep");
    a_sleep_pins_frozen: assert property (s_asleep |-> $stable(port_d_out) && $stable(port_d_oe) && $stable(ale))
        else $error("pins moved in sleep");
    a_sleep_no_done: assert property (s_asleep |-> !mem_done)
        else $error("access ended in sleep");
    a_done_one_clk: assert property (mem_done |=> !mem_done)
        else $error("done longer than one clock");
    // a sleep entered in the address phase freezes ale while chip enable is forced high
    a_addr_owns_port: assert property (ale && !$past(sleep_idle) |-> port_d_oe == 8'hff && port_d_out == mem_addr && !chip_enable_n)
        else $error("address phase not on port");
    a_bus_ttl_input: assert property (ale |-> ttl_buffers)
        else $error("ttl off in bus phase");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
endmodule
bind xbc_bus_ctrl xbc_bus_ctrl_asserts i_xbc_bus_ctrl_asserts
(
    .sys_clk(sys_clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .sleep_idle(sleep_idle), .mem_addr(mem_addr), .mem_done(mem_done), .port_d_out(port_d_out),
    .port_d_oe(port_d_oe), .ttl_buffers(ttl_buffers), .ale(ale), .chip_enable_n(chip_enable_n),
    .upper_byte_enable_n(upper_byte_enable_n), .lower_byte_enable_n(lower_byte_enable_n)
);
`default_nettype wire

// [sim/tb.sv]
/*
 bench: axi4-lite register tasks, bus access task, memory partner.
 assumes xbc_bus_ctrl and xbc_mem_model.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
    logic        sys_clk = 1'b0, rst = 1'b1, cycle_enable = 1'b0, sleep_idle = 1'b0, psp_drive = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp, en_q;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        mem_req = 1'b0, mem_write = 1'b0, mem_upper = 1'b0, mem_done, ttl_buffers, ale;
    logic [7:0]  mem_addr = 8'h00, psp_rd_data = 8'h00, mem_rdata, port_d_in, port_d_out, port_d_oe;
    logic [7:0]  ad_high_out, hi_q, lo_q;
    logic        write_high_strobe, chip_enable_n, upper_byte_enable_n, lower_byte_enable_n, hi_seen;
    int          num_errors = 0, check_count = 0, cyc = 0, tdiv = 1, tcnt = 0, tk = 0;
    xbc_bus_ctrl i_xbc_bus_ctrl
    (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cycle_enable(cycle_enable), .sleep_idle(sleep_idle),
        .mem_req(mem_req), .mem_write(mem_write), .mem_upper(mem_upper), .mem_addr(mem_addr),
        .mem_done(mem_done), .mem_rdata(mem_rdata), .psp_rd_data(psp_rd_data), .psp_drive(psp_drive),
        .port_d_in(port_d_in), .port_d_out(port_d_out), .port_d_oe(port_d_oe), .ad_high_out(ad_high_out),
        .ttl_buffers(ttl_buffers), .ale(ale), .write_high_strobe(write_high_strobe),
        .chip_enable_n(chip_enable_n), .upper_byte_enable_n(upper_byte_enable_n),
        .lower_byte_enable_n(lower_byte_enable_n)
    );
    xbc_mem_model i_xbc_mem_model
    (
        .sys_clk(sys_clk), .ale(ale), .chip_enable_n(chip_enable_n),
        .port_d_out(port_d_out), .port_d_oe(port_d_oe), .port_d_in(port_d_in)
    );
    always #20 sys_clk = ~sys_clk;
    task automatic final_report();
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // instruction tick every tdiv+1 clocks; the cycle count cuts a hang
    always @(posedge sys_clk)
    begin
        tcnt <= (tcnt >= tdiv) ? 0 : tcnt + 1;
        cycle_enable <= (tcnt == 0);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            final_report();
        end
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        `CHK("rdata", e, d)
    endtask
    // start just after a tick so tick counts line up between runs
    task automatic acc(input logic w, input logic up, input logic [7:0] a);
        do
            @(posedge sys_clk);
        while (!cycle_enable);
        mem_req <= 1'b1;
        mem_write <= w;
        mem_upper <= up;
        mem_addr <= a;
        tk = 0;
        hi_seen = 1'b0;
        do
        begin
            @(posedge sys_clk);
            tk += int'(cycle_enable);
            if (write_high_strobe && !hi_seen)
            begin
                hi_seen = 1'b1;
                hi_q = ad_high_out;
                lo_q = port_d_out;
                en_q = {upper_byte_enable_n, lower_byte_enable_n};
            end
        end
        while (!mem_done);
        mem_req <= 1'b0;
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        `CHK("oe", 8'h00, port_d_oe)
        rdc(12'h000, 32'h0);
        rdc(12'h008, 32'hff);
        wr(12'h000, 32'hff, 4'h1);
        rdc(12'h000, 32'hb3);
        rd(12'h100);
        `CHK("rresp", 2'b10, resp)
        wr(12'h100, 32'h1, 4'h1);
        `CHK("bresp", 2'b10, resp)
        wr(12'h000, 32'h80, 4'h1);
        wr(12'h00c, 32'ha5, 4'h1);
        wr(12'h008, 32'h0f, 4'h1);
        repeat (2) @(posedge sys_clk);
        `CHK("oe", 8'hf0, port_d_oe)
        `CHK("out", 4'ha, port_d_out[7:4])
        `CHK("ttl", 1'b0, ttl_buffers)
        rdc(12'h00c, 32'ha5);
        wr(12'h010, 32'h4, 4'h1);
        psp_rd_data <= 8'h3c;
        psp_drive <= 1'b1;
        repeat (2) @(posedge sys_clk);
        `CHK("psp", 17'h1ff3c, {ttl_buffers, port_d_oe, port_d_out})
        acc(1'b0, 1'b0, 8'h22);
        `CHK("rdata", 8'h78, mem_rdata)
        repeat (2) @(posedge sys_clk);
        `CHK("psp", 8'h3c, port_d_out)
        psp_drive <= 1'b0;
        wr(12'h010, 32'h0, 4'h1);
        for (int c = 3; c >= 0; c--)
        begin
            tdiv = c + 1;
            wr(12'h000, 32'(c) << 4, 4'h1);
            acc(1'b0, 1'b0, 8'h40 + 8'(c));
            `CHK("rdata", 8'h1a ^ 8'(c), mem_rdata)
            // take, address, wait count plus one, data and done ticks
            `CHK("ticks", 8 - c, tk)
        end
        `CHK("ttl", 1'b1, ttl_buffers)
        fork
            acc(1'b0, 1'b0, 8'h55);
            begin
                repeat (12) @(posedge sys_clk);
                sleep_idle <= 1'b1;
                repeat (6) @(posedge sys_clk);
                sleep_idle <= 1'b0;
            end
        join
        `CHK("rdata", 8'h0f, mem_rdata)
        wr(12'h010, 32'h1, 4'h1);
        wr(12'h000, 32'h30, 4'h1);
        `CHK("bresp", 2'b00, resp)
        rdc(12'h000, 32'h0);
        wr(12'h010, 32'h2, 4'h1);
        wr(12'h014, 32'hc3a5, 4'h3);
        wr(12'h000, 32'h32, 4'h1);
        acc(1'b1, 1'b1, 8'h10);
        `CHK("word", 17'h1c3a5, {hi_seen, hi_q, lo_q})
        `CHK("enables", 2'b00, en_q)
        wr(12'h000, 32'h31, 4'h1);
        acc(1'b1, 1'b1, 8'h11);
        `CHK("byte", 17'h1a5a5, {hi_seen, hi_q, lo_q})
        `CHK("enables", 2'b01, en_q)
        wr(12'h010, 32'h0, 4'h1);
        acc(1'b1, 1'b1, 8'h12);
        `CHK("narrow", 1'b0, hi_seen)
        final_report();
    end
endmodule
`default_nettype wire
